// *** logic/irq_vector_unit.sv ***
// Two-level vectored interrupt controller for an 8-bit core
`timescale 1ns/10ps

// Operation
// R1: Source event sets pending flag regardless of enable
// R2: Enabled pending flag raises request for long call
// R3: Global enable zero blocks every source
// R4: Each source has own enable; disabled ignored
// R5: Ext and timer 0/1 flags clear on vectoring
// R6: Flag still set after return re-requests
// R7: Software write of one acts as event
// R8: Two levels; high preempts low only
// R9: Per-source priority bit, low after reset
// R10: Higher level wins, then lowest order number
// R11: Requests sampled and decoded every cycle
// R12: Detect in one cycle, call takes four
// R13: One instruction completes after return first
// R14: Worst response bounded to eighteen cycles
// R15: Equal or higher in service holds requests
// R16: After exit highest pending is served next
// R17: Fixed vectors eight bytes apart from 0x0003
// R18: Return ends in-service state of current level
// R19: Global enable is bit 7, overrides masks
// R20: Request, vector, level out; acknowledge marks service
module irq_vector_unit #(
    parameter int NSRC = irq_unit_pkg::NUM_SRC   // Number of sources
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // Peripheral flag sources, one-cycle event pulses
    input  wire logic [NSRC-1:0]          srcEvent,
    // Software access to the pending flags
    input  wire logic [NSRC-1:0]          swSet,
    input  wire logic [NSRC-1:0]          swClear,
    // Enable and priority configuration
    input  wire logic [7:0]               basic_enable_reg,
    input  wire logic [7:0]               extended_enable_reg,
    input  wire logic [NSRC-1:0]          priorityHigh,
    // Core handshake
    input  wire logic                     irqAck,
    input  wire logic                     returnDone,
    input  wire logic                     instrDone,
    output irq_unit_pkg::irq_req_t        irqReq,
    // Status back to software
    output logic [NSRC-1:0]               pendingFlags,
    output logic                          inServiceLow,
    output logic                          inServiceHigh
);

    // Whole state, current and next
    irq_unit_pkg::irq_state_t state_reg;
    irq_unit_pkg::irq_state_t state_next;

    // Combined per-source enable and eligible set
    logic [14:0] enableMask;     // Individual enables in order
    logic        globalEn;       // Global enable bit
    logic [14:0] eligible;       // Enabled and pending
    logic [14:0] eligHigh;       // Eligible at high level
    logic [14:0] eligLow;        // Eligible at low level
    logic        winValid;       // Some source may be served now
    logic        winHigh;        // Level of the winner
    logic [3:0]  winIndex;       // Order number of the winner
    logic [14:0] clrOnVector;    // Hardware clear on vectoring

    // Enable map: basic reg bits 0..6 are orders 0..6, extended bits 0..7 orders 7..14
    assign globalEn   = basic_enable_reg[irq_unit_pkg::GLOBAL_BIT];      // see R19
    assign enableMask = {extended_enable_reg, basic_enable_reg[6:0]};    // see R4

    // Eligibility, recomputed every cycle from the live flags
    always_comb begin
        eligible = state_reg.pending & enableMask & {15{globalEn}};     // see R3 see R11
        eligHigh = eligible & priorityHigh[14:0];                        // see R9
        eligLow  = eligible & ~priorityHigh[14:0];
    end

    // Priority decode: high level first, lowest order number within a level
    always_comb begin
        logic [14:0] pick;
        pick     = '0;
        winHigh  = 1'b0;
        winIndex = 4'h0;
        winValid = 1'b0;
        // A high routine is never preempted; a low one only by high
        if (!state_reg.svcHigh && (eligHigh != 15'h0000)) begin        // see R8 see R10
            pick    = eligHigh;
            winHigh = 1'b1;
        end else if (!state_reg.svcHigh && !state_reg.svcLow) begin     // see R15
            pick    = eligLow;
        end
        // Lowest set bit wins; loop runs downward so smallest index lands last
        for (int i = 14; i >= 0; i--) begin
            if (pick[i]) begin
                winIndex = 4'(i);                                         // see R16
                winValid = 1'b1;
            end
        end
        // No new request while the post-return instruction is pending
        if (state_reg.holdOff) begin                                      // see R13
            winValid = 1'b0;
        end
    end

    // Next-state logic
    always_comb begin
        state_next  = state_reg;
        clrOnVector = '0;
        // Flags auto-cleared when the core acknowledges the vector
        if (irqAck && state_reg.req.valid) begin
            clrOnVector[state_reg.req.index] =
                irq_unit_pkg::AUTO_CLR_MSK[state_reg.req.index];         // see R5
        end
        // Set wins over clear, so an event in the clearing cycle is kept
        state_next.pending = (state_reg.pending & ~swClear[14:0] & ~clrOnVector)
                           | srcEvent[14:0] | swSet[14:0];                // see R1 see R7
        // Acknowledge marks the winning level in service
        if (irqAck && state_reg.req.valid) begin                          // see R20
            if (state_reg.req.high) begin
                state_next.svcHigh = 1'b1;
            end else begin
                state_next.svcLow  = 1'b1;
            end
        end else if (returnDone) begin
            // Return ends the most recent level only
            if (state_reg.svcHigh) begin                                  // see R18
                state_next.svcHigh = 1'b0;
            end else begin
                state_next.svcLow  = 1'b0;
            end
            state_next.holdOff = 1'b1;                                    // see R13
        end
        // Hold-off ends when the following instruction completes
        if (state_reg.holdOff && instrDone && !returnDone) begin
            state_next.holdOff = 1'b0;                                    // see R6
        end
        // Request register: one detect cycle, dropped once taken
        state_next.req.valid  = winValid && !(irqAck && state_reg.req.valid); // see R2 see R12
        state_next.req.high   = winHigh;
        state_next.req.index  = winIndex;
        state_next.req.vector = irq_unit_pkg::VEC_BASE
                              + (16'(winIndex) * irq_unit_pkg::VEC_STEP);  // see R17
    end

    // State register; all flags clear and levels low after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg            <= '0;
            state_reg.req.vector <= irq_unit_pkg::VEC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register
    assign irqReq        = state_reg.req;                                  // see R14
    assign pendingFlags  = state_reg.pending;
    assign inServiceLow  = state_reg.svcLow;
    assign inServiceHigh = state_reg.svcHigh;

    // An event on source 3 always lands in its flag
    chk_event_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
        srcEvent[3] |=> pendingFlags[3]) else $error("event lost");       // see R1

    // Global disable keeps request low
    chk_global_blocks: assert property (@(posedge clk) disable iff (!arst_n)
        !basic_enable_reg[7] |=> !irqReq.valid) else $error("request while disabled"); // see R3

    // Disabled source never wins
    chk_disabled_src: assert property (@(posedge clk) disable iff (!arst_n)
        irqReq.valid |-> enableMask[irqReq.index]) else $error("disabled source won"); // see R4

    // Auto-cleared source drops its flag on ack
    chk_auto_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (irqAck && irqReq.valid && irqReq.index == 4'h1 && !srcEvent[1] && !swSet[1])
        |=> !pendingFlags[1]) else $error("timer flag not cleared");     // see R5

    // High routine never preempted
    chk_no_high_preempt: assert property (@(posedge clk) disable iff (!arst_n)
        inServiceHigh |=> !irqReq.valid) else $error("high routine preempted"); // see R8

    // Low in service admits only high requests
    chk_low_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (inServiceLow && $past(inServiceLow)) && irqReq.valid |-> irqReq.high)
        else $error("equal level served");                               // see R15

    // Vector matches index
    chk_vector_map: assert property (@(posedge clk) disable iff (!arst_n)
        irqReq.valid |-> irqReq.vector == 16'h0003 + {9'h000, irqReq.index, 3'h0})
        else $error("bad vector");                                        // see R17

    // Eligible request seen within one cycle
    chk_detect_one: assert property (@(posedge clk) disable iff (!arst_n)
        (winValid && !irqAck) |=> irqReq.valid) else $error("slow detect"); // see R12

    // Return blocks requests until the next instruction
    chk_return_hold: assert property (@(posedge clk) disable iff (!arst_n)
        returnDone ##1 !instrDone |=> !irqReq.valid) else $error("early re-entry"); // see R13

    // Return clears a level
    chk_return_ends: assert property (@(posedge clk) disable iff (!arst_n)
        (returnDone && !irqAck && inServiceHigh) |=> !inServiceHigh)
        else $error("service not ended");                                 // see R18

    // Ordering of the handshake as the core sees it:
    // request stands until acknowledged, then drops on the next edge,
    // the level stays in service until the return, and one more
    // instruction must finish before the next request may appear.
    // The properties below pin down each step except the level staying in service.

    // Per-source flag checks; one copy of each property per order number
    for (genvar g = 0; g < irq_unit_pkg::NUM_SRC; g++) begin : gen_flag_chk
        // Hardware event lands in its flag on the next edge
        chk_flag_on_event: assert property (@(posedge clk) disable iff (!arst_n) // see R1
            srcEvent[g] |=> pendingFlags[g]) else $error("event flag not set");

        // Software write of one acts like an event
        chk_flag_on_write: assert property (@(posedge clk) disable iff (!arst_n) // see R7
            swSet[g] |=> pendingFlags[g]) else $error("written flag not set");

        // Flag stays set until software or the auto clear drops it
        chk_flag_holds: assert property (@(posedge clk) disable iff (!arst_n) // see R5
            pendingFlags[g] && !swClear[g]
            && !(irqAck && irqReq.valid && (irqReq.index == 4'(g))
            && irq_unit_pkg::AUTO_CLR_MSK[g]) |=> pendingFlags[g])
            else $error("flag dropped on its own");

        // Flag never rises without an event or a write
        chk_flag_no_spurious: assert property (@(posedge clk) disable iff (!arst_n) // see R1
            !pendingFlags[g] && !srcEvent[g] && !swSet[g] |=> !pendingFlags[g])
            else $error("flag rose on its own");

        // Auto-cleared sources drop their flag once vectored
        chk_flag_auto_clr: assert property (@(posedge clk) disable iff (!arst_n) // see R5
            irqAck && irqReq.valid && (irqReq.index == 4'(g))
            && irq_unit_pkg::AUTO_CLR_MSK[g] && !srcEvent[g] && !swSet[g]
            |=> !pendingFlags[g]) else $error("vectored flag kept");
    end

    // Taken request drops so one vectoring yields one long call
    chk_ack_drops: assert property (@(posedge clk) disable iff (!arst_n) // see R20
        irqAck && irqReq.valid |=> !irqReq.valid) else $error("request kept after ack");

    // Acknowledge of a high winner marks high in service
    chk_ack_high: assert property (@(posedge clk) disable iff (!arst_n) // see R20
        irqAck && irqReq.valid && irqReq.high |=> inServiceHigh)
        else $error("high level not marked");

    // Acknowledge of a low winner marks low in service
    chk_ack_low: assert property (@(posedge clk) disable iff (!arst_n) // see R20
        irqAck && irqReq.valid && !irqReq.high |=> inServiceLow)
        else $error("low level not marked");

    // High service starts only through an acknowledge
    chk_high_by_ack: assert property (@(posedge clk) disable iff (!arst_n) // see R20
        !inServiceHigh && !(irqAck && irqReq.valid && irqReq.high) |=> !inServiceHigh)
        else $error("high level set without ack");

    // Low service starts only through an acknowledge
    chk_low_by_ack: assert property (@(posedge clk) disable iff (!arst_n) // see R20
        !inServiceLow && !(irqAck && irqReq.valid && !irqReq.high) |=> !inServiceLow)
        else $error("low level set without ack");

    // Return with no high routine open closes the low one
    chk_return_low: assert property (@(posedge clk) disable iff (!arst_n) // see R18
        (returnDone && !(irqAck && irqReq.valid) && !inServiceHigh) |=> !inServiceLow)
        else $error("low service not ended");

    // Request that is not taken stands while its source stays eligible
    chk_req_stands: assert property (@(posedge clk) disable iff (!arst_n) // see R2
        irqReq.valid && !irqAck && !returnDone && !state_reg.holdOff
        && eligible[irqReq.index] |=> irqReq.valid)
        else $error("request withdrawn");

    // Nothing eligible means no request on the next edge
    chk_idle_no_req: assert property (@(posedge clk) disable iff (!arst_n) // see R2
        (eligible == 15'h0000) |=> !irqReq.valid) else $error("request with no source");

    // A low winner means no high source was eligible
    chk_high_first: assert property (@(posedge clk) disable iff (!arst_n) // see R10
        irqReq.valid && !irqReq.high |-> ($past(eligHigh) == 15'h0000))
        else $error("low served over high");

    // High winner has no eligible high source of smaller order
    chk_order_high: assert property (@(posedge clk) disable iff (!arst_n) // see R10
        irqReq.valid && irqReq.high
        |-> (($past(eligHigh) & ((15'h0001 << irqReq.index) - 15'h0001)) == 15'h0000))
        else $error("high order skipped");

    // Low winner has no eligible low source of smaller order
    chk_order_low: assert property (@(posedge clk) disable iff (!arst_n) // see R16
        irqReq.valid && !irqReq.high
        |-> (($past(eligLow) & ((15'h0001 << irqReq.index) - 15'h0001)) == 15'h0000))
        else $error("low order skipped");

    // Winner order stays inside the source table
    chk_index_range: assert property (@(posedge clk) disable iff (!arst_n) // see R10
        irqReq.valid |-> (irqReq.index <= 4'hE)) else $error("index past table");

    // Vector stays between the first and the last table entry
    chk_vector_range: assert property (@(posedge clk) disable iff (!arst_n) // see R17
        irqReq.valid |-> (irqReq.vector inside {[16'h0003:16'h0073]}))
        else $error("vector outside table");

    // Request only follows a cycle with the global enable set
    chk_global_needed: assert property (@(posedge clk) disable iff (!arst_n) // see R19
        irqReq.valid |-> $past(basic_enable_reg[7])) else $error("request without global");

    // Low routine is preempted by an eligible high source
    chk_high_preempts: assert property (@(posedge clk) disable iff (!arst_n) // see R8
        state_reg.svcLow && !state_reg.svcHigh && !state_reg.holdOff
        && (eligHigh != 15'h0000) && !(irqAck && irqReq.valid)
        |=> irqReq.valid && irqReq.high) else $error("high not let through");

    // Hold-off is raised only by a return
    chk_hold_by_return: assert property (@(posedge clk) disable iff (!arst_n) // see R13
        !state_reg.holdOff && !returnDone |=> !state_reg.holdOff)
        else $error("hold-off without return");

    // Return arms the hold-off for one instruction
    chk_return_arms: assert property (@(posedge clk) disable iff (!arst_n) // see R13
        returnDone && !(irqAck && irqReq.valid) |=> state_reg.holdOff)
        else $error("hold-off not armed");

    // No request may appear while the hold-off stands
    chk_hold_blocks: assert property (@(posedge clk) disable iff (!arst_n) // see R15
        state_reg.holdOff |=> !irqReq.valid) else $error("request during hold-off");

    // Hold-off ends with the instruction after the return
    chk_hold_ends: assert property (@(posedge clk) disable iff (!arst_n) // see R6
        state_reg.holdOff && instrDone && !returnDone |=> !state_reg.holdOff)
        else $error("hold-off stuck");

    // Once free, a waiting source is requested one edge later; the core's
    // own timing then keeps the whole response within its bound
    chk_resume_bound: assert property (@(posedge clk) disable iff (!arst_n) // see R14
        (state_reg.holdOff && instrDone && !returnDone) ##1
        ((eligible != 15'h0000) && !inServiceHigh && !inServiceLow)
        |=> irqReq.valid) else $error("late request after return");

    // First request after a quiet spell takes one detect cycle
    chk_min_resp: assert property (@(posedge clk) disable iff (!arst_n) // see R12
        (eligible != 15'h0000) && !state_reg.svcHigh && !state_reg.svcLow
        && !state_reg.holdOff && !irqReq.valid |=> irqReq.valid)
        else $error("detect took too long");

endmodule : irq_vector_unit

// *** shared/irq_unit_pkg.sv ***
// Shared constants and carrier types for the two-level vectored interrupt unit
package irq_unit_pkg;
    localparam int               NUM_SRC      = 15;         // Sources, fixed order 0..14
    localparam logic [15:0]      VEC_BASE     = 16'h0003;   // Vector of order 0
    localparam logic [15:0]      VEC_STEP     = 16'h0008;   // Spacing between vectors
    localparam logic [15:0]      VEC_RESET    = 16'h0000;   // Reset vector, top priority
    localparam int               GLOBAL_BIT   = 7;          // Global enable in basic enable reg
    localparam logic [14:0]      AUTO_CLR_MSK = 15'h000F;   // Ext 0, timer 0, ext 1, timer 1
    localparam logic [14:0]      PRIO_RST     = 15'h0000;   // All sources low after reset
    localparam int               DETECT_CYC   = 1;          // Cycles to detect a request
    localparam int               CALL_CYC     = 4;          // Cycles of the long call
    localparam int               MIN_RESP     = DETECT_CYC + CALL_CYC;
    localparam int               RETURN_FROM_IRQ_CYC     = 5;
    localparam int               DIV_CYC      = 8;
    localparam int               MAX_RESP     = DETECT_CYC + RETURN_FROM_IRQ_CYC + DIV_CYC + CALL_CYC;

    // Request presented to the core
    typedef struct packed {
        logic        valid;     // Request line
        logic        high;      // Winning level
        logic [3:0]  index;     // Winning source order number
        logic [15:0] vector;    // Long-call target
    } irq_req_t;

    // Whole state of the controller
    typedef struct packed {
        logic [14:0] pending;   // Pending flags
        logic        svcLow;    // Low-level routine in service
        logic        svcHigh;   // High-level routine in service
        logic        holdOff;   // One instruction must finish after return
        irq_req_t    req;       // Registered request
    } irq_state_t;
endpackage : irq_unit_pkg

// *** test/core_model.sv ***
// Core sequencer model: takes requests, runs a short routine, returns
`timescale 1ns/10ps
module core_model (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Request side and test controls
    input  wire irq_unit_pkg::irq_req_t irqReq,
    input  wire logic                   stall,
    input  wire logic                   keepFlag,
    // Core handshake and the routine's flag clear
    output logic                        irqAck,
    output logic                        returnDone,
    output logic                        instrDone,
    output logic [14:0]                 swClear
);
    int          step;    // Routine progress, 0 when idle
    logic [14:0] clrMsk;  // Flag the routine clears
    // Falling edge, so the unit samples settled values; no nesting modelled
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {irqAck, returnDone, instrDone, swClear} <= '0;
            step <= 0;
        end else begin
            {irqAck, returnDone, instrDone, swClear} <= '0;
            if (step == 0 && irqReq.valid && !stall) begin
                irqAck <= 1'b1;
                clrMsk <= keepFlag ? 15'h0000 : 15'h0001 << irqReq.index;
                step   <= 1;
            end else if (step != 0) begin
                step       <= (step == 4) ? 0 : step + 1;
                swClear    <= (step == 1) ? clrMsk : 15'h0000;
                returnDone <= (step == 3);
                instrDone  <= (step == 4);
            end
        end
    end
endmodule : core_model

// *** test/irq_vector_unit_tb.sv ***
// Self-checking bench for the two-level vectored interrupt unit
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module irq_vector_unit_tb;
    logic                   clk = 0, arst_n = 0, stall = 0, keepFlag = 0; // Clock, reset, model
    logic [14:0]            srcEvent = '0, swSet = '0, prioHigh = '0, m;  // Stimulus
    logic [14:0]            swClear, pendingFlags;                       // Flags
    logic [7:0]             basicEn = 8'hFF, extEn = 8'hFF;               // All enables on
    logic                   irqAck, returnDone, instrDone, inSvcLow, inSvcHigh;
    irq_unit_pkg::irq_req_t irqReq;                                      // Request to core
    int                     err_count = 0, cmp_count = 0, seed = 32'h0187, e;
    int                     expQ[$];                                     // Expected winners
    always #50 clk = ~clk;
    // Model stalls at random, so requests must stand until taken
    always @(negedge clk) stall <= $random(seed);
    irq_vector_unit irq_vector_unit_inst (.clk(clk), .arst_n(arst_n), .srcEvent(srcEvent),
        .swSet(swSet), .swClear(swClear), .basic_enable_reg(basicEn),
        .extended_enable_reg(extEn), .priorityHigh(prioHigh), .irqAck(irqAck),
        .returnDone(returnDone), .instrDone(instrDone), .irqReq(irqReq),
        .pendingFlags(pendingFlags), .inServiceLow(inSvcLow), .inServiceHigh(inSvcHigh));
    core_model core_model_inst (.clk(clk), .arst_n(arst_n), .irqReq(irqReq), .stall(stall),
        .keepFlag(keepFlag), .irqAck(irqAck), .returnDone(returnDone),
        .instrDone(instrDone), .swClear(swClear));
    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // Bounded wait until every expected service has been taken
    task automatic drain();
        for (int n = 0; n < 300 && expQ.size() != 0; n++) @(negedge clk);
        repeat (8) @(negedge clk);
        `CHK("leftover", 0, expQ.size())
    endtask : drain
    // One-cycle peripheral event or software write of ones
    task automatic pulse(input logic [14:0] ev, input logic sw);
        @(negedge clk);
        if (sw) swSet = ev;
        else srcEvent = ev;
        @(negedge clk);
        {swSet, srcEvent} = '0;
    endtask : pulse
    // Watcher: old values are read at the edge, before the unit's updates land
    always @(posedge clk) begin
        if (irqReq.valid && irqAck) begin
            e = expQ.size() ? expQ.pop_front() : 99;
            `CHK("vector", irq_unit_pkg::VEC_BASE + 16'(e) * irq_unit_pkg::VEC_STEP, irqReq.vector)
            `CHK("level", prioHigh[e[3:0]], irqReq.high)
            @(negedge clk);
            `CHK("pending", e > 3, pendingFlags[e[3:0]])
            `CHK("in service", prioHigh[e[3:0]], inSvcHigh)
            `CHK("in service low", !prioHigh[e[3:0]], inSvcLow)
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        arst_n = 1;
        `CHK("reset req", '0, irqReq)
        `CHK("reset flags", 15'h0000, pendingFlags)
        // Every source alone; odd ones set by software
        for (int i = 0; i < 15; i++) begin
            expQ.push_back(i);
            pulse(15'h0001 << i, i[0]);
            `CHK("detect", 1'b0, irqReq.valid)
            @(negedge clk);
            `CHK("request", 1'b1, irqReq.valid)
            drain();
        end
        // Global off, then one source masked
        basicEn = 8'h7F;
        pulse(15'h0010, 0);
        repeat (3) @(negedge clk);
        `CHK("flag set", 1'b1, pendingFlags[4])
        `CHK("global off", 1'b0, irqReq.valid)
        basicEn = 8'hEF;
        repeat (3) @(negedge clk);
        `CHK("masked", 1'b0, irqReq.valid)
        expQ.push_back(4);
        basicEn = 8'hFF;
        drain();
        // Simultaneous mixed-level requests: high first, then by order
        for (int r = 0; r < 6; r++) begin
            m = $random(seed);
            prioHigh = $random(seed);
            for (int h = 1; h >= 0; h--)
                for (int i = 0; i < 15; i++)
                    if (m[i] && prioHigh[i] == h) expQ.push_back(i);
            pulse(m, r[0]);
            drain();
        end
        // Routine leaves its flag set: served again after return
        keepFlag <= 1;
        expQ = '{6, 6};
        pulse(15'h0040, 0);
        wait (expQ.size() == 1);
        keepFlag <= 0;
        drain();
        report_and_stop();
    end
    // Watchdog well beyond the expected run
    initial begin
        #2_000_000;
        err_count++;
        report_and_stop();
    end
endmodule : irq_vector_unit_tb
